// ---- hdl/hdlc_status_irq.sv ----
// Function
// - latch tx end on marked fetch or underrun
// - status read clears latched flags and the interrupt they raise
// - interrupt needs flag, bit mask, master enable
// - live flag: tx fifo below low watermark
// - live flag: rx fifo above high watermark
// - latch rx start on opening byte
// - latch rx end on every message finish
// - underrun sends abort, re-armed by write
// - four-bit tx level in 16-byte steps
// - live tx empty bit, never interrupts
// - latch overrun, re-armed after fifo read
// - live rx empty bit
// - latch abort only inside a packet
// - no new abort before valid flag
// - rx high threshold 16 plus 32 per code
// - tx fifo holds 256, ignores writes full
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_status_params.svh"

module hdlc_status_irq #(
  parameter int CNT_W = 9 // fifo occupancy width, holds 0..256
) (
  input wire logic ref_clk,                 // 50 MHz system clock
  input wire logic arst_n,                  // async reset, active low
  input wire logic [7:0] bus_addr,          // control port address
  input wire logic bus_rd_stb,              // one-cycle read strobe
  input wire logic bus_wr_stb,              // one-cycle write strobe
  input wire logic [15:0] bus_wdata,        // write data
  output logic [15:0] bus_rdata_q,          // read data, held until next read
  input wire logic master_hdlc_irq_en,      // hdlc enable of master mask
  input wire logic [2:0] tx_low_mark_sel,   // tx low watermark code
  input wire logic [2:0] rx_high_mark_sel,  // rx high watermark code
  input wire logic tx_byte_fetch,           // transmitter takes a byte
  input wire logic tx_message_end_mark,     // fetched byte ends message
  input wire logic tx_fifo_dry,             // tx fifo ran dry mid packet
  input wire logic tx_fifo_wr,              // host writes tx fifo
  input wire logic [CNT_W-1:0] tx_fifo_count, // tx fifo bytes held
  input wire logic rx_open_byte,            // opening byte detected
  input wire logic rx_msg_end,              // message finished, any status
  input wire logic rx_overrun,              // rx fifo overrun
  input wire logic rx_fifo_rd,              // host reads rx fifo
  input wire logic [CNT_W-1:0] rx_fifo_count, // rx fifo bytes held
  input wire logic rx_ones_run7,            // seven ones in a row seen
  input wire logic rx_in_packet,            // receiver inside a packet
  input wire logic rx_flag_seen,            // valid flag sequence seen
  output logic irq_q,                       // interrupt, active high
  output logic tx_send_abort_q,             // pulse: send abort now
  output logic tx_fifo_full_q               // tx fifo at capacity
);
  localparam logic [15:0] LATCH_MASK = `LATCH_BITS;
  localparam logic [15:0] IRQ_MASK = `IRQ_BITS;
  localparam logic [CNT_W-1:0] TX_DEPTH = CNT_W'(`TX_FIFO_DEPTH);

  // ==========================================================================
  // decoding helpers
  function automatic logic [CNT_W-1:0] wm_thresh(input logic [2:0] sel);
    wm_thresh = CNT_W'(`WM_BASE + `WM_STEP * int'(sel));
  endfunction : wm_thresh

  function automatic hdlc_status_pkg::arm_e next_arm(
    input hdlc_status_pkg::arm_e cur,
    input logic fire,
    input logic rearm
  );
    case (cur)
      hdlc_status_pkg::ARM_READY: begin
        next_arm = fire ? hdlc_status_pkg::ARM_SPENT : cur;
      end
      hdlc_status_pkg::ARM_SPENT: begin
        next_arm = rearm ? hdlc_status_pkg::ARM_READY : cur;
      end
      default: begin
        next_arm = hdlc_status_pkg::ARM_READY;
      end
    endcase
  endfunction : next_arm

  // ==========================================================================
  // re-arm state of underrun, overrun and abort
  hdlc_status_pkg::arm_e udr_arm_q, udr_arm_d;
  hdlc_status_pkg::arm_e ovr_arm_q, ovr_arm_d;
  hdlc_status_pkg::arm_e abt_arm_q, abt_arm_d;
  logic udr_fire, ovr_fire, abt_fire, tx_wr_taken;

  always_comb begin
    tx_wr_taken = tx_fifo_wr && (tx_fifo_count < TX_DEPTH);
    udr_fire = tx_fifo_dry && (udr_arm_q == hdlc_status_pkg::ARM_READY);
    ovr_fire = rx_overrun && (ovr_arm_q == hdlc_status_pkg::ARM_READY);
    abt_fire = rx_ones_run7 && rx_in_packet &&
               (abt_arm_q == hdlc_status_pkg::ARM_READY);
    udr_arm_d = next_arm(udr_arm_q, udr_fire, tx_wr_taken);
    ovr_arm_d = next_arm(ovr_arm_q, ovr_fire, rx_fifo_rd);
    abt_arm_d = next_arm(abt_arm_q, abt_fire, rx_flag_seen);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      udr_arm_q <= hdlc_status_pkg::ARM_READY;
      ovr_arm_q <= hdlc_status_pkg::ARM_READY;
      abt_arm_q <= hdlc_status_pkg::ARM_READY;
    end else begin
      udr_arm_q <= udr_arm_d;
      ovr_arm_q <= ovr_arm_d;
      abt_arm_q <= abt_arm_d;
    end
  end

  // ==========================================================================
  // latched event flags
  logic status_read, mask_read, mask_write;
  logic [15:0] latch_set, flag_q;

  always_comb begin
    status_read = bus_rd_stb && (bus_addr == `STATUS_OFS);
    mask_read = bus_rd_stb && (bus_addr == `IMASK_OFS);
    mask_write = bus_wr_stb && (bus_addr == `IMASK_OFS);
    latch_set = '0;
    latch_set[`B_TX_END] = (tx_byte_fetch && tx_message_end_mark) || udr_fire;
    latch_set[`B_RX_START] = rx_open_byte;
    latch_set[`B_RX_END] = rx_msg_end;
    latch_set[`B_TX_UNDR] = udr_fire;
    latch_set[`B_RX_OVR] = ovr_fire;
    latch_set[`B_RX_ABT] = abt_fire;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (LATCH_MASK[gi]) begin : g_latch
        event_flag u_flag (
          .ref_clk(ref_clk),
          .arst_n(arst_n),
          .set(latch_set[gi]),
          .clr(status_read),
          .q(flag_q[gi])
        );
      end else begin : g_none
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // live status and the assembled word
  hdlc_status_pkg::status_word_t status_w;

  always_comb begin
    status_w = flag_q;
    status_w[`B_TX_LOW] = tx_fifo_count < wm_thresh(tx_low_mark_sel);
    status_w[`B_RX_HIGH] = rx_fifo_count > wm_thresh(rx_high_mark_sel);
    status_w[`B_TX_LVL_HI:`B_TX_LVL_LO] =
      (tx_fifo_count >= TX_DEPTH) ? `LEVEL_MAX :
      4'(tx_fifo_count >> `LEVEL_SHIFT);
    status_w[`B_TX_EMPTY] = (tx_fifo_count == '0);
    status_w[`B_RX_EMPTY] = (rx_fifo_count == '0);
  end

  // ==========================================================================
  // mask register, read port and outputs
  logic [15:0] mask_q, mask_d, rdata_d;
  logic irq_d, abort_d, full_d;

  always_comb begin
    // level and empty bits cannot be unmasked
    mask_d = mask_write ? (bus_wdata & IRQ_MASK) : mask_q;
    if (status_read) begin
      rdata_d = status_w;
    end else if (mask_read) begin
      rdata_d = mask_q;
    end else if (bus_rd_stb) begin
      rdata_d = '0;
    end else begin
      rdata_d = bus_rdata_q;
    end
    irq_d = master_hdlc_irq_en && |(status_w & mask_q & IRQ_MASK);
    abort_d = udr_fire;
    full_d = tx_fifo_count >= TX_DEPTH;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= `IMASK_RESET;
      bus_rdata_q <= `RDATA_RESET;
      irq_q <= 1'b0;
      tx_send_abort_q <= 1'b0;
      tx_fifo_full_q <= 1'b0;
    end else begin
      mask_q <= mask_d;
      bus_rdata_q <= rdata_d;
      irq_q <= irq_d;
      tx_send_abort_q <= abort_d;
      tx_fifo_full_q <= full_d;
    end
  end

  // ==========================================================================
  // checks
  tx_end_set_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (tx_byte_fetch && tx_message_end_mark) |=> flag_q[`B_TX_END])
    else $error("tx end flag not set after marked fetch");

  read_clears_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (status_read && !rx_msg_end) |=> !flag_q[`B_RX_END])
    else $error("rx end flag survived a status read");

  irq_gate_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!master_hdlc_irq_en || mask_q == '0) |=> !irq_q)
    else $error("interrupt raised while masked");

  low_mark_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (status_read && tx_fifo_count == '0) |=> bus_rdata_q[`B_TX_LOW])
    else $error("empty tx fifo not below low watermark");

  high_mark_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (status_read && rx_fifo_count == '0) |=> !bus_rdata_q[`B_RX_HIGH])
    else $error("empty rx fifo reported above high watermark");

  underrun_abort_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (tx_fifo_dry && udr_arm_q == hdlc_status_pkg::ARM_READY) |=>
    (tx_send_abort_q && flag_q[`B_TX_UNDR] && flag_q[`B_TX_END]))
    else $error("underrun did not abort and latch");

  level_full_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (status_read && tx_fifo_count == TX_DEPTH) |=>
    (bus_rdata_q[`B_TX_LVL_HI:`B_TX_LVL_LO] == 4'hF &&
     !bus_rdata_q[`B_TX_EMPTY]))
    else $error("full tx fifo level misreported");

  abort_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (!flag_q[`B_RX_ABT] && !(rx_ones_run7 && rx_in_packet)) |=>
    !flag_q[`B_RX_ABT])
    else $error("abort flag set outside a packet");

  abort_hold_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (abt_arm_q == hdlc_status_pkg::ARM_SPENT && !rx_flag_seen) |=>
    (abt_arm_q == hdlc_status_pkg::ARM_SPENT && !$rose(flag_q[`B_RX_ABT])))
    else $error("abort re-armed without a flag");

  set_wins_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (status_read && rx_open_byte) |=>
    (flag_q[`B_RX_START] && bus_rdata_q == $past(status_w)))
    else $error("event lost or read data not pre-clear");
endmodule : hdlc_status_irq

`default_nettype wire

// ---- hdl/hdlc_status_params.svh ----
`ifndef HDLC_STATUS_PARAMS_SVH
`define HDLC_STATUS_PARAMS_SVH

// ==========================================================================
// register offsets on the control port
`define STATUS_OFS 8'h86
`define IMASK_OFS 8'h88

// ==========================================================================
// status word bit positions
`define B_TX_END 0
`define B_TX_LOW 2
`define B_RX_HIGH 4
`define B_RX_START 5
`define B_RX_END 6
`define B_TX_UNDR 7
`define B_TX_LVL_LO 8
`define B_TX_LVL_HI 11
`define B_TX_EMPTY 12
`define B_RX_OVR 13
`define B_RX_EMPTY 14
`define B_RX_ABT 15

// ==========================================================================
// masks and reset values
`define LATCH_BITS 16'hA0E1
`define IRQ_BITS 16'hA0F5
`define IMASK_RESET 16'h0000
`define RDATA_RESET 16'h0000

// ==========================================================================
// fifo geometry and watermark thresholds
`define WM_BASE 16
`define WM_STEP 32
`define TX_FIFO_DEPTH 256
`define LEVEL_SHIFT 4
`define LEVEL_MAX 4'hF

`endif

// ---- hdl/hdlc_status_pkg.sv ----
`default_nettype none

package hdlc_status_pkg;
  // re-arm state of a once-per-occurrence event
  typedef enum logic [1:0] {
    ARM_READY = 2'b01,
    ARM_SPENT = 2'b10
  } arm_e;

  typedef logic [15:0] status_word_t;
endpackage : hdlc_status_pkg

`default_nettype wire

// ---- hdl/event_flag.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// sticky event bit, cleared by a read; a set in the clear cycle wins
module event_flag (
  input wire logic ref_clk, // system clock
  input wire logic arst_n,  // async reset, active low
  input wire logic set,     // event pulse
  input wire logic clr,     // clear pulse
  output logic q            // flag state
);
  logic q_d;

  always_comb begin
    q_d = set | (q & ~clr);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else begin
      q <= q_d;
    end
  end
endmodule : event_flag

`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// host cpu on the control port; strobes last one cycle, data sampled after
module host_model (
  input wire logic ref_clk,            // system clock
  input wire logic [15:0] bus_rdata_q, // read data from the block
  output logic [7:0] bus_addr,         // register address
  output logic bus_rd_stb,             // read strobe
  output logic bus_wr_stb,             // write strobe
  output logic [15:0] bus_wdata        // write data
);
  initial begin
    bus_addr = 8'h00;
    bus_rd_stb = 1'h0;
    bus_wr_stb = 1'h0;
    bus_wdata = 16'h0000;
  end

  task rd(input logic [7:0] a, output logic [15:0] d);
    bus_addr <= a;
    bus_rd_stb <= 1'h1;
    @(posedge ref_clk);
    bus_rd_stb <= 1'h0;
    #1 d = bus_rdata_q;
    @(posedge ref_clk);
  endtask : rd

  task wr(input logic [7:0] a, input logic [15:0] v);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr_stb <= 1'h1;
    @(posedge ref_clk);
    bus_wr_stb <= 1'h0;
    bus_wdata <= ~v;
  endtask : wr
endmodule : host_model

`default_nettype wire

// ---- dv/hdlc_status_irq_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_status_params.svh"

module hdlc_status_irq_test;
  localparam int FETCH = 0;
  localparam int DRY = 1;
  localparam int TWR = 2;
  localparam int OPEN = 3;
  localparam int MEND = 4;
  localparam int OVR = 5;
  localparam int RRD = 6;
  localparam int ONES = 7;
  localparam int FLAG = 8;
  logic ref_clk = 1'h0;
  logic arst_n = 1'h0;
  logic master_en = 1'h0;
  logic mark = 1'h0;
  logic in_pkt = 1'h0;
  logic [2:0] tsel = 3'h0;
  logic [2:0] rsel = 3'h0;
  logic [8:0] ev = 9'h000;
  logic [8:0] tcnt = 9'h000;
  logic [8:0] rcnt = 9'h000;
  logic [7:0] addr;
  logic rd_stb;
  logic wr_stb;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic irq;
  logic abt;
  logic full;
  logic [15:0] d;
  int n_mismatch = 0;
  int check_count = 0;

  always #10 ref_clk = ~ref_clk;

  host_model host (.ref_clk(ref_clk), .bus_rdata_q(rdata),
    .bus_addr(addr), .bus_rd_stb(rd_stb), .bus_wr_stb(wr_stb),
    .bus_wdata(wdata));

  hdlc_status_irq dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .bus_addr(addr), .bus_rd_stb(rd_stb), .bus_wr_stb(wr_stb),
    .bus_wdata(wdata), .bus_rdata_q(rdata), .master_hdlc_irq_en(master_en),
    .tx_low_mark_sel(tsel), .rx_high_mark_sel(rsel),
    .tx_byte_fetch(ev[FETCH]), .tx_message_end_mark(mark),
    .tx_fifo_dry(ev[DRY]), .tx_fifo_wr(ev[TWR]), .tx_fifo_count(tcnt),
    .rx_open_byte(ev[OPEN]), .rx_msg_end(ev[MEND]), .rx_overrun(ev[OVR]),
    .rx_fifo_rd(ev[RRD]), .rx_fifo_count(rcnt), .rx_ones_run7(ev[ONES]),
    .rx_in_packet(in_pkt), .rx_flag_seen(ev[FLAG]), .irq_q(irq),
    .tx_send_abort_q(abt), .tx_fifo_full_q(full));

  // ==========================================================================
  // shared helpers
  task test_done;
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task chk_word(input hdlc_status_pkg::status_word_t got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t output %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task pulse(input int i);
    ev <= 9'h001 << i;
    @(posedge ref_clk);
    ev <= 9'h000;
  endtask : pulse

  task rs(input logic [15:0] m, e);
    host.rd(`STATUS_OFS, d);
    chk_word(d & m, e);
  endtask : rs

  // samples after the current edge, then moves to the next one
  task obs(input int w, input logic e);
    #1 chk_bit(w == 0 ? irq : (w == 1 ? abt : full), e);
    @(posedge ref_clk);
  endtask : obs

  // ==========================================================================
  // scenarios
  task t_reset;
    rs(16'hFFFF, 16'h5004); // empty fifos
    host.rd(`IMASK_OFS, d);
    chk_word(d, `IMASK_RESET); // mask starts closed
    host.rd(8'h00, d);
    chk_word(d, 16'h0000); // unmapped read is zero
  endtask : t_reset

  task t_tx_end;
    tcnt <= 9'h064;
    pulse(FETCH);
    rs(16'h0001, 16'h0000); // unmarked byte
    mark <= 1'h1; // last byte only
    pulse(FETCH);
    mark <= 1'h0;
    rs(16'h0001, 16'h0001); // marked byte
    rs(16'h0001, 16'h0000); // cleared by read
  endtask : t_tx_end

  task t_underrun;
    pulse(DRY);
    obs(1, 1'h1); // abort sent
    obs(1, 1'h0); // one pulse
    rs(16'h0081, 16'h0081); // both latched
    pulse(DRY);
    rs(16'h0080, 16'h0000); // not re-armed
    pulse(TWR);
    @(posedge ref_clk);
    pulse(DRY);
    rs(16'h0080, 16'h0080); // re-armed by write
    tcnt <= 9'h100;
    pulse(TWR);
    @(posedge ref_clk);
    pulse(DRY);
    rs(16'h0080, 16'h0000); // write ignored when full
    tcnt <= 9'h064;
  endtask : t_underrun

  task t_level;
    int cs[5];
    logic [8:0] c;
    logic [3:0] l;
    cs = '{0, 15, 16, 255, 256};
    foreach (cs[k]) begin
      c = 9'(cs[k]);
      l = c[8] ? 4'hF : c[7:4];
      tcnt <= c;
      rs(16'h1F04, {3'h0, c == 0, l, 5'h00, c < 16, 2'h0});
      obs(2, c[8]); // full at capacity
    end
  endtask : t_level

  task t_marks;
    int th;
    for (int k = 0; k < 8; k++) begin
      th = 16 + 32 * k;
      tsel <= 3'(k);
      rsel <= 3'(k);
      tcnt <= 9'(th - 1);
      rcnt <= 9'(th + 1);
      rs(16'h0014, 16'h0014); // past threshold
      tcnt <= 9'(th);
      rcnt <= 9'(th);
      rs(16'h0014, 16'h0000); // at threshold
    end
    tcnt <= 9'h064;
    rcnt <= 9'h000;
  endtask : t_marks

  task t_irq;
    host.wr(`IMASK_OFS, 16'hFFFF);
    host.rd(`IMASK_OFS, d);
    chk_word(d, 16'hA0F5); // maskable bits
    host.wr(`IMASK_OFS, 16'h0040);
    host.rd(`STATUS_OFS, d);
    master_en <= 1'h1;
    pulse(OPEN);
    obs(0, 1'h0); // no flag yet
    obs(0, 1'h0); // masked flag
    pulse(MEND);
    obs(0, 1'h0); // irq one cycle later
    obs(0, 1'h1); // unmasked flag
    master_en <= 1'h0;
    obs(0, 1'h1); // disable takes a cycle
    obs(0, 1'h0); // master disabled
    master_en <= 1'h1;
    rs(16'h0060, 16'h0060); // both latched
    obs(0, 1'h0); // released by read
  endtask : t_irq

  task t_abort;
    pulse(ONES);
    rs(16'h8000, 16'h0000); // outside packet
    in_pkt <= 1'h1;
    pulse(ONES);
    rs(16'h8000, 16'h8000); // inside packet
    pulse(ONES);
    rs(16'h8000, 16'h0000); // no flag yet
    pulse(FLAG);
    @(posedge ref_clk);
    pulse(ONES);
    rs(16'h8000, 16'h8000); // after flag
    in_pkt <= 1'h0;
  endtask : t_abort

  task t_overrun;
    pulse(OVR);
    rs(16'h2000, 16'h2000); // latched
    pulse(OVR);
    rs(16'h2000, 16'h0000); // not re-armed
    pulse(RRD);
    @(posedge ref_clk);
    pulse(OVR);
    rs(16'h2000, 16'h2000); // re-armed by read
  endtask : t_overrun

  task t_coinc;
    ev <= 9'h001 << OPEN;
    fork
      host.rd(`STATUS_OFS, d);
      begin
        @(posedge ref_clk);
        ev <= 9'h000;
      end
    join
    chk_word(d & 16'h0020, 16'h0000); // pre-clear value
    rs(16'h0020, 16'h0020); // event kept
  endtask : t_coinc

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(posedge ref_clk);
    t_reset();
    t_tx_end();
    t_underrun();
    t_level();
    t_marks();
    t_irq();
    t_abort();
    t_overrun();
    t_coinc();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
endmodule : hdlc_status_irq_test

`default_nettype wire
